// ===== hw/sipo_defs.svh
`ifndef SIPO_DEFS_SVH
`define SIPO_DEFS_SVH

// number of shift register stages and latch bits
`define SIPO_STAGES 8
// index of the final stage, which feeds the cascade outputs
`define SIPO_FINAL_STAGE 7
// depth of the captured-word buffer
`define SIPO_FIFO_DEPTH 32
// reset value of shift register, latch and cascade outputs
`define SIPO_STAGE_RST 8'h00
`define SIPO_BIT_RST 1'b0

`endif

// ===== hw/sipo_pkg.sv
`include "sipo_defs.svh"

package sipo_pkg;

  // the four pins the host controller drives
  typedef struct packed {
    logic shift_clk; // shift clock pin
    logic data;      // serial data pin
    logic strobe;    // latch-transfer strobe pin
    logic out_en;    // output enable pin
  } pin_in_t;

  // parallel output pins with their three-state enable
  typedef struct packed {
    logic [`SIPO_STAGES-1:0] data; // latch contents
    logic oe;                      // high while the pins are driven
  } par_out_t;

  // serial cascade outputs
  typedef struct packed {
    logic final_stage; // last stage, updates on rising shift clock
    logic delayed;     // copy of last stage, updates on falling shift clock
  } cascade_t;

endpackage : sipo_pkg

// ===== hw/word_fifo.sv
`timescale 1ns/100ps
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk_i,          // system clock
  input wire logic rst_n_i,            // async reset, active low
  input wire logic [WIDTH-1:0] wr_data_i, // word to store
  input wire logic wr_valid_i,         // store request
  output logic wr_ready_o,             // room for one more word
  output logic [WIDTH-1:0] rd_data_o,  // oldest stored word
  output logic rd_valid_o,             // a word is waiting
  input wire logic rd_ready_i          // consumer takes the word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];  // storage array
  logic [AW-1:0] wr_ptr;          // next slot to write
  logic [AW-1:0] rd_ptr;          // next slot to read
  logic [AW:0] count;             // words held

  wire push = wr_valid_i & wr_ready_o;  // accepted write
  wire pop = rd_valid_o & rd_ready_i;   // accepted read

  // full and empty come straight from the count, so they never lie
  assign wr_ready_o = (count != (AW+1)'(DEPTH));
  assign rd_valid_o = (count != '0);
  assign rd_data_o = mem[rd_ptr];

  // wrap a pointer at the depth, which need not be a power of two
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
  endfunction : bump

  // storage write, no reset needed on the array
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= wr_data_i;
    end
  end

  // pointers and occupancy
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= bump(wr_ptr);
      if (pop) rd_ptr <= bump(rd_ptr);
      if (push & ~pop) count <= count + (AW+1)'(1);
      else if (pop & ~push) count <= count - (AW+1)'(1);
    end
  end

endmodule : word_fifo

// ===== hw/serial_in_parallel_out_latch.sv
`timescale 1ns/100ps
`include "sipo_defs.svh"
module serial_in_parallel_out_latch #(
  parameter int STAGES = `SIPO_STAGES,
  parameter int FIFO_DEPTH = `SIPO_FIFO_DEPTH
) (
  input wire logic sys_clk_i,                      // system clock, 100 MHz
  input wire logic rst_n_i,                        // async reset, active low
  input wire sipo_pkg::pin_in_t pins_i,            // asynchronous host pins
  output sipo_pkg::par_out_t par_o,                // parallel pins and enable
  output sipo_pkg::cascade_t cascade_o,            // serial cascade outputs
  output logic [STAGES-1:0] word_o,                // captured word to user logic
  output logic word_valid_o,                       // captured word waiting
  input wire logic word_ready_i,                   // user logic takes the word
  output logic capture_ready_o                     // buffer has room for a capture
);
  import sipo_pkg::*;

  // three-stage synchronisers for all four pins
  pin_in_t sync_a;     // first stage, read only by sync_b
  pin_in_t sync_b;     // second stage
  pin_in_t sync_c;     // third stage
  pin_in_t level;      // filtered pin levels
  pin_in_t level_prev; // filtered levels one cycle back
  pin_in_t next_level; // next filtered levels

  logic [STAGES-1:0] shift;      // shift register, bit 0 is the first stage
  logic [STAGES-1:0] latch;      // storage latch
  logic cascade_delayed;         // falling-edge copy of the final stage
  logic out_en;                  // registered output enable

  // a filtered bit only moves when the second and third stages agree,
  // which keeps a single metastable or glitchy sample from counting
  assign next_level = pin_in_t'((sync_b & sync_c) | (level & (sync_b ^ sync_c)));

  // edge helpers shared by the clock and strobe detectors
  function automatic logic rose(input logic was, input logic now);
    rose = now & ~was;
  endfunction : rose

  function automatic logic fell(input logic was, input logic now);
    fell = was & ~now;
  endfunction : fell

  // decoded pin events, each a one-cycle pulse except strobe_high, which is the filtered strobe level
  wire clk_rise = rose(level_prev.shift_clk, level.shift_clk);
  wire clk_fall = fell(level_prev.shift_clk, level.shift_clk);
  wire strobe_fall = fell(level_prev.strobe, level.strobe);
  wire strobe_high = level.strobe;

  // next shift contents: stage 1 takes data, every stage n takes n-1,
  // so the seventh stage lands in the eighth on the same edge
  wire [STAGES-1:0] next_shift = {shift[STAGES-2:0], level.data};

  // pin synchroniser chain
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end else begin
      sync_a <= pins_i;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // filtered levels and their history for edge detection
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level <= '0;
      level_prev <= '0;
    end else begin
      level <= next_level;
      level_prev <= level;
    end
  end

  // shift register; the reset to zero is only a defined start, the
  // host must still load eight bits before the contents mean anything
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift <= `SIPO_STAGE_RST;
    end else if (clk_rise) begin
      shift <= next_shift;
    end
  end

  // delayed cascade bit: untouched on rising edges
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cascade_delayed <= `SIPO_BIT_RST;
    end else if (clk_fall) begin
      cascade_delayed <= shift[`SIPO_FINAL_STAGE];
    end
  end

  // storage latch: follows the shift register while the strobe is high;
  // when the strobe falls the update stops, so it keeps the last value
  // seen while high (one system cycle behind the shift register)
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch <= `SIPO_STAGE_RST;
    end else if (strobe_high) begin
      latch <= shift;
    end
  end

  // registered output enable for the parallel pins
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_en <= 1'b0;
    end else begin
      out_en <= level.out_en;
    end
  end

  // parallel pins: data always from the latch, enable gates the drivers;
  // shifting and cascade outputs do not look at the enable at all
  assign par_o.data = latch;
  assign par_o.oe = out_en;

  // cascade outputs
  assign cascade_o.final_stage = shift[`SIPO_FINAL_STAGE];
  assign cascade_o.delayed = cascade_delayed;

  // each completed transfer (strobe fall) pushes the held word into the
  // buffer; when the buffer is full the capture still updates the pins
  // but the word is not queued, and capture_ready_o shows that
  word_fifo #(
    .WIDTH(STAGES),
    .DEPTH(FIFO_DEPTH)
  ) u_word_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .wr_data_i(latch),
    .wr_valid_i(strobe_fall),
    .wr_ready_o(capture_ready_o),
    .rd_data_o(word_o),
    .rd_valid_o(word_valid_o),
    .rd_ready_i(word_ready_i)
  );

endmodule : serial_in_parallel_out_latch

// ===== verification/sipo_chk.sv
`timescale 1ns/100ps
module sipo_chk (
  input wire logic sys_clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire sipo_pkg::pin_in_t pins_i, // host pins
  input wire sipo_pkg::par_out_t par_o, // parallel pins
  input wire sipo_pkg::cascade_t cascade_o // cascade outputs
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // pin windows long enough to cover the input filter delay
  sequence stb_hi; pins_i.strobe[*8] ##1 pins_i.strobe[*2]; endsequence
  sequence stb_lo; !pins_i.strobe[*8] ##1 !pins_i.strobe[*2]; endsequence
  a_reset_clear: assert property ($rose(rst_n_i) |-> par_o == '0)
    else $error("outputs not clear after reset");
  a_final_stable: assert property ($changed(cascade_o.final_stage) |-> $stable(cascade_o.delayed))
    else $error("delayed output moved with final stage");
  a_delay_copy: assert property ($changed(cascade_o.delayed) |->
    cascade_o.delayed == cascade_o.final_stage && $stable(cascade_o.final_stage))
    else $error("delayed output not a copy");
  a_hiz_oe: assert property (!pins_i.out_en[*8] |-> !par_o.oe)
    else $error("parallel pins driven while disabled");
  a_oe_on: assert property (pins_i.out_en[*8] |-> par_o.oe)
    else $error("parallel pins floating while enabled");
  a_latch_hold: assert property (stb_lo |-> $stable(par_o.data))
    else $error("latch moved while strobe low");
  a_shift_step: assert property (stb_hi ##0 $changed(par_o.data) |->
    par_o.data[7:1] == $past(par_o.data[6:0]))
    else $error("transparent latch did not step by one");
  a_latch_final: assert property (stb_hi |-> par_o.data[7] == $past(cascade_o.final_stage))
    else $error("latch top bit differs from final stage");
  c_strobe_fall: cover property (pins_i.strobe ##1 !pins_i.strobe);
  c_delay_move: cover property ($changed(cascade_o.delayed));
  c_oe_off: cover property ($fell(par_o.oe));
endmodule : sipo_chk
bind serial_in_parallel_out_latch sipo_chk chk_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .pins_i(pins_i), .par_o(par_o), .cascade_o(cascade_o));

// ===== verification/sipo_host.sv
`timescale 1ns/100ps
module sipo_host (
  input wire logic sys_clk_i, // system clock
  output sipo_pkg::pin_in_t pins_o // host pins
);
  import sipo_pkg::*;
  initial pins_o = '0;
  // every level is kept at least four cycles so the filter never drops it
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : hold
  task automatic set_oe(input logic en);
    pins_o.out_en <= en;
    hold(8);
  endtask : set_oe
  task automatic set_strobe(input logic lvl);
    pins_o.strobe <= lvl;
    hold(10);
  endtask : set_strobe
  // bit for the last parallel output goes first
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      pins_o.data <= b[i];
      hold(4);
      pins_o.shift_clk <= 1'b1;
      hold(4);
      pins_o.shift_clk <= 1'b0;
      hold(4);
      pins_o.data <= ~b[i]; // stale data line never shows the old bit
      hold(4); // let the inverted level stand before the next bit
    end
  endtask : send_byte
endmodule : sipo_host

// ===== verification/test_serial_in_parallel_out_latch.sv
`timescale 1ns/100ps
module test_serial_in_parallel_out_latch;
  import sipo_pkg::*;
  typedef struct packed {logic [7:0] b; logic oe;} row_t;
  logic sys_clk_i = 1'b0; // system clock
  logic rst_n_i = 1'b0; // reset, active low
  logic word_ready_i = 1'b0; // consumer accepts
  pin_in_t pins;
  par_out_t par;
  cascade_t casc;
  logic [7:0] word;
  logic word_valid;
  logic cap_ready;
  logic [7:0] prev;
  int num_errors = 0;
  int compares = 0;
  row_t rows [5] = '{'{8'hA5, 1'b1}, '{8'h01, 1'b1}, '{8'h80, 1'b0}, '{8'hFF, 1'b1}, '{8'h00, 1'b1}};
  always #5 sys_clk_i = ~sys_clk_i;
  sipo_host host_u (.sys_clk_i(sys_clk_i), .pins_o(pins));
  serial_in_parallel_out_latch dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .pins_i(pins),
    .par_o(par), .cascade_o(casc), .word_o(word), .word_valid_o(word_valid),
    .word_ready_i(word_ready_i), .capture_ready_o(cap_ready));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  // bounded wait for a queued word, compare, then take it
  task automatic pop(input logic [7:0] exp);
    int n;
    n = 0;
    while (word_valid !== 1'b1 && n < 20) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 20) begin
      num_errors++;
      finish_test();
    end
    chk(word, exp);
    @(posedge sys_clk_i);
    word_ready_i <= 1'b1;
    @(posedge sys_clk_i);
    word_ready_i <= 1'b0;
    @(negedge sys_clk_i);
  endtask : pop
  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(negedge sys_clk_i);
    chk(par.data, 8'h00);
    chk({6'h00, word_valid, cap_ready}, 8'h01);
    prev = 8'h00;
    foreach (rows[i]) begin
      host_u.set_oe(rows[i].oe);
      host_u.send_byte(rows[i].b);
      chk(par.data, prev);
      host_u.set_strobe(1'b1);
      host_u.set_strobe(1'b0);
      chk(par.data, rows[i].b);
      chk({7'h00, par.oe}, {7'h00, rows[i].oe});
      chk({7'h00, casc.final_stage}, {7'h00, rows[i].b[7]});
      chk({7'h00, casc.delayed}, {7'h00, rows[i].b[7]});
      pop(rows[i].b);
      prev = rows[i].b;
    end
    // strobe held high while shifting: latch follows the stages
    host_u.set_strobe(1'b1);
    host_u.send_byte(8'h3C);
    chk(par.data, 8'h3C);
    host_u.set_strobe(1'b0);
    // fill the buffer past full, then drain it empty
    repeat (32) begin
      host_u.set_strobe(1'b1);
      host_u.set_strobe(1'b0);
    end
    chk({7'h00, cap_ready}, 8'h00);
    repeat (32) pop(8'h3C);
    chk({7'h00, word_valid}, 8'h00);
    // mid-run reset with a non-zero latch: everything must clear again
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(negedge sys_clk_i);
    chk(par.data, 8'h00);
    chk({6'h00, word_valid, cap_ready}, 8'h01);
    finish_test();
  end
endmodule : test_serial_in_parallel_out_latch
